// *** core_model.sv ***
// Behavioural core that accepts vectors and runs returns.
`timescale 1ns/100ps
module core_model (
  input  wire logic        clk_i,      // Core clock.
  input  wire logic        rst_i,      // Synchronous reset.
  input  wire logic        push_i,     // Push request.
  input  wire logic        load_i,     // Load request.
  input  wire logic [15:0] vector_i,   // Vector address.
  input  wire logic        ready_en_i, // Accept entries.
  input  wire logic        ret_req_i,  // Run one return.
  output logic             ready_o,    // At an entry point.
  output logic             return_o,   // Return pulse.
  output logic      [15:0] pc_o,       // Program counter.
  output int               depth_o     // Nesting depth.
);
  logic pushed;
  always @(posedge clk_i) begin
    pushed <= push_i;
    ready_o <= ready_en_i && !rst_i;
    return_o <= ret_req_i && depth_o > 0;
    if (rst_i)
      depth_o <= 0;
    else if (load_i && pushed) begin
      pc_o <= vector_i;
      depth_o <= depth_o + 1;
    end else if (ret_req_i && depth_o > 0)
      depth_o <= depth_o - 1;
  end
endmodule

// *** irq_arbiter.sv ***
// Level and polling-order arbiter for the interrupt sources.
`timescale 1ns/100ps
module irq_arbiter (
  input  wire logic [10:0] pend_i,    // Enabled pending requests.
  input  wire logic [10:0] high_i,    // Per-source high-level select.
  input  wire logic        act_hi_i,  // High-level routine running.
  input  wire logic        act_lo_i,  // Low-level routine running.
  output logic             valid_o,   // A request may be taken.
  output logic [3:0]       idx_o,     // Winning source index.
  output logic             level_o    // Winning level, 1 is high.
);

  logic [10:0] elig_hi;
  logic [10:0] elig_lo;

  // --------------------------------------------------------------------
  // Per-source eligibility against the running levels.
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NUM_SRC; g++) begin : g_src
      assign elig_hi[g] = pend_i[g] & high_i[g] & ~act_hi_i;
      assign elig_lo[g] = pend_i[g] & ~high_i[g] & ~act_hi_i & ~act_lo_i;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pick the lowest index, high level taking precedence.
  // --------------------------------------------------------------------
  // high before low.
  always_comb begin
    valid_o = 1'b0;
    idx_o   = 4'h0;
    level_o = 1'b0;
    for (int i = irq_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (elig_lo[i]) begin
        valid_o = 1'b1;
        idx_o   = 4'(i);
        level_o = 1'b0;
      end
    end
    for (int i = irq_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (elig_hi[i]) begin
        valid_o = 1'b1;
        idx_o   = 4'(i);
        level_o = 1'b1;
      end
    end
  end

endmodule

// *** irq_checker.sv ***
// Port assertions for the interrupt priority block.
`timescale 1ns/100ps
module irq_checker (
  input wire logic        clk_i,                 // Clock.
  input wire logic        rst_i,                 // Reset.
  input wire logic        wb_cyc_i,              // Cycle.
  input wire logic        wb_stb_i,              // Strobe.
  input wire logic [31:0] wb_dat_o,              // Read data.
  input wire logic        wb_ack_o,              // Acknowledge.
  input wire logic        power_down_i,          // Powered down.
  input wire logic        interval_match_flag_i, // Interval match.
  input wire logic        push_pc_o,             // Push.
  input wire logic        load_pc_o,             // Load.
  input wire logic [15:0] vector_o,              // Vector.
  input wire logic        wake_o                 // Wake.
);
  // All checks share the core clock and its reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Each bus request gets exactly one single-cycle acknowledge.
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack is not one pulse");
  // Read data is a byte and is zero outside an acknowledge.
  property p_dat; wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o == 32'h0); endproperty
  a_dat: assert property (p_dat) else $error("read data not clean");
  property p_push; push_pc_o |=> load_pc_o && $stable(vector_o); endproperty
  a_push: assert property (p_push) else $error("push not followed by load");
  property p_load; load_pc_o |-> $past(push_pc_o); endproperty
  a_load: assert property (p_load) else $error("load without push");
  property p_vec; push_pc_o |-> vector_o[2:0] == 3'h3 && vector_o <= 16'h005B && vector_o != 16'h004B; endproperty
  a_vec: assert property (p_vec) else $error("vector off the table");
  property p_gap; push_pc_o |=> !push_pc_o [*2]; endproperty
  a_gap: assert property (p_gap) else $error("entries too close");
  property p_pd; push_pc_o && power_down_i && $past(power_down_i, 2) |-> vector_o == 16'h0053; endproperty
  a_pd: assert property (p_pd) else $error("wrong power-down vector");
  property p_wake; wake_o |-> $past(power_down_i) && $past(interval_match_flag_i); endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
endmodule

bind two_level_interrupt_priority irq_checker u_irq_checker (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .power_down_i,
  .interval_match_flag_i, .push_pc_o, .load_pc_o, .vector_o, .wake_o);

// *** irq_prio_pkg.sv ***
// Constants shared by the two-level interrupt priority block.
package irq_prio_pkg;

  // --------------------------------------------------------------------
  // Register indices; the byte address on the bus is four times these.
  // --------------------------------------------------------------------
  localparam logic [7:0] IDX_PRIMARY_ENABLE = 8'hA8;
  localparam logic [7:0] IDX_SECONDARY      = 8'hA9;
  localparam logic [7:0] IDX_PRIMARY_PRIO   = 8'hB8;
  localparam logic [7:0] IDX_CORE_STATUS    = 8'hC0;
  localparam logic [7:0] IDX_EVENT_STATUS   = 8'hC1;
  localparam logic [7:0] IDX_EVENT_MASK     = 8'hC2;

  // --------------------------------------------------------------------
  // Reset values.
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_SECONDARY      = 8'hA0;
  localparam logic [7:0] RST_PRIMARY_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIMARY_PRIO   = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK     = 8'h00;

  // --------------------------------------------------------------------
  // Secondary enable and priority register fields.
  // --------------------------------------------------------------------
  localparam int SEC_SERIAL_PERIPH_EN   = 0;
  localparam int SEC_SUPPLY_MON_EN      = 1;
  localparam int SEC_MUST_BE_ZERO       = 3;
  localparam int SEC_SERIAL_PERIPH_PRIO = 4;
  localparam int SEC_SUPPLY_MON_PRIO    = 5;
  localparam int SEC_INTERVAL_PRIO      = 6;
  localparam int SEC_INTERVAL_EN        = 2;
  localparam int SEC_UNUSED_TOP         = 7;

  // --------------------------------------------------------------------
  // Primary enable and priority fields (shared bit layout except bit 7: global enable vs watchdog).
  // --------------------------------------------------------------------
  localparam int PRI_EXT0      = 0;
  localparam int PRI_TIMER0    = 1;
  localparam int PRI_EXT1      = 2;
  localparam int PRI_TIMER1    = 3;
  localparam int PRI_SERIAL    = 4;
  localparam int PRI_TIMER2    = 5;
  localparam int PRI_CONVERTER = 6;
  localparam int PRI_GLOBAL_EN = 7;
  localparam int PRI_WATCHDOG  = 7;

  // --------------------------------------------------------------------
  // Event status bits.
  // --------------------------------------------------------------------
  localparam int EVT_ENTRY      = 0;
  localparam int EVT_WAKE       = 1;
  localparam int EVT_STRAY_RETI = 2;

  // --------------------------------------------------------------------
  // Sources in polling order, index 0 is polled first.
  // --------------------------------------------------------------------
  localparam int NUM_SRC       = 11;
  localparam int SRC_SUPPLY    = 0;
  localparam int SRC_WATCHDOG  = 1;
  localparam int SRC_EXT0      = 2;
  localparam int SRC_CONVERTER = 3;
  localparam int SRC_TIMER0    = 4;
  localparam int SRC_EXT1      = 5;
  localparam int SRC_TIMER1    = 6;
  localparam int SRC_SER_PERIPH = 7;
  localparam int SRC_SERIAL    = 8;
  localparam int SRC_TIMER2    = 9;
  localparam int SRC_INTERVAL  = 10;

  // Vector address for each source, indexed in polling order.
  localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
    16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
    16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053
  };

  // Entry sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH = 3'b010,
    ST_LOAD = 3'b100
  } entry_state_t;

endpackage

// *** tb.sv ***
// Self-checking bench for the interrupt priority block.
`timescale 1ns/100ps
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, pd = 0, rdy = 0, ret = 0;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, rd, v, dat, seed = 32'hE9F5;
  logic [10:0] req = 0, h;
  logic [15:0] vec;
  logic ack, push, load, wake, irq, cr, crt, pnd;
  int num_errors = 0, tests_run = 0, cyc_n = 0, depth;
  int src[3] = '{7, 0, 10};
  two_level_interrupt_priority u_two_level_interrupt_priority (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat),
    .wb_ack_o(ack), .supply_monitor_request_i(req[0]),
    .watchdog_request_i(req[1]), .external_request_zero_i(req[2]),
    .converter_done_i({req[3], 1'b0}), .timer_zero_overflow_i(req[4]),
    .external_request_one_i(req[5]), .timer_one_overflow_i(req[6]),
    .serial_periph_request_i({1'b0, req[7]}),
    .serial_port_request_i({req[8], 1'b0}),
    .timer_two_events_i({1'b0, req[9]}), .interval_match_flag_i(req[10]),
    .core_ready_i(cr), .core_return_i(crt), .power_down_i(pd),
    .push_pc_o(push), .load_pc_o(load), .vector_o(vec),
    .irq_pending_o(pnd), .wake_o(wake), .irq_o(irq));
  core_model u_core_model (.clk_i, .rst_i, .push_i(push),
    .load_i(load), .vector_i(vec), .ready_en_i(rdy), .ret_req_i(ret),
    .ready_o(cr), .return_o(crt), .pc_o(), .depth_o(depth));
  // Clock and a watchdog on the run length.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (++cyc_n > 20000) begin
      num_errors++;
      end_of_test;
    end
  function logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Winner: high level first, then polling order.
  function logic [15:0] win(input logic [10:0] p, input logic [10:0] hi);
    for (int i = 0; i < 11; i++) if (p[i] && hi[i]) return irq_prio_pkg::VECTOR_TABLE[i];
    for (int i = 0; i < 11; i++) if (p[i]) return irq_prio_pkg::VECTOR_TABLE[i];
    return 16'h0;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One classic Wishbone cycle, held until acknowledged.
  task wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    cyc <= 0;
  endtask
  task take(input logic [15:0] e);
    int n;
    n = 0;
    do @(posedge clk_i); while (load !== 1'b1 && ++n < 40);
    chk({load, vec}, {1'b1, e});
  endtask
  task none;
    repeat (12) begin
      @(posedge clk_i);
      chk({push, pnd}, 0);
    end
  endtask
  task back;
    @(posedge clk_i);
    ret <= 1;
    @(posedge clk_i);
    ret <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: registers, enables, levels, nesting, power-down.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rdy <= 1;
    wb(0, 12'h2A4, 0);
    chk(rd, 32'hA0);
    wb(0, 12'h3FC, 0);
    chk(rd, 0);
    wb(1, 12'h2A4, 8'h72);
    wb(0, 12'h2A4, 0);
    chk(rd, 32'hF2);
    wb(1, 12'h2A0, 8'h80);
    for (int k = 0; k < 3; k++) begin
      wb(1, 12'h2A4, 0);
      req[src[k]] <= 1;
      none;
      wb(1, 12'h2A4, 8'h1 << k);
      take(irq_prio_pkg::VECTOR_TABLE[src[k]]);
      req <= 0;
      back;
    end
    chk(irq, 0);
    wb(1, 12'h2A0, 8'hFF);
    for (int r = 0; r < 10; r++) begin
      v = rnd();
      wb(1, 12'h2E0, v[7:0]);
      wb(1, 12'h2A4, {1'b0, v[10:8], 4'h7});
      h = {v[10], v[5], v[4], v[8], v[3], v[2], v[1], v[6], v[0], v[7], v[9]};
      req <= v[26:16] | 11'h1;
      take(win(v[26:16] | 11'h1, h));
      req <= 0;
      back;
    end
    wb(1, 12'h2E0, 8'h05);
    wb(1, 12'h2A4, 8'h07);
    wb(1, 12'h308, 8'h01);
    req <= 11'h010;
    take(16'h000B);
    req <= 0;
    repeat (2) @(posedge clk_i);
    chk(irq, 1);
    wb(0, 12'h304, 0);
    chk(rd, 1);
    repeat (2) @(posedge clk_i);
    chk(irq, 0);
    req <= 11'h020;
    take(16'h0013);
    req <= 11'h004;
    none;
    chk(depth, 2);
    back;
    take(16'h0003);
    req <= 0;
    repeat (3) back;
    rdy <= 0;
    pd <= 1;
    wb(1, 12'h2A4, 8'h04);
    req <= 11'h404;
    take(16'h0053);
    chk(wake, 1);
    req <= 0;
    pd <= 0;
    rdy <= 1;
    back;
    end_of_test;
  end
endmodule

// *** two_level_interrupt_priority.sv ***
// Two-level interrupt priority and vectoring block with Wishbone registers.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps

// What this block does
// - Interval counter request passes only while secondary bit 2 is set.
// - Supply monitor request passes only while secondary bit 1 is set.
// - Serial-peripheral request passes only while secondary bit 0 is set.
// - Secondary bit 6 makes the interval counter high priority.
// - Secondary bit 5 makes the supply monitor high priority.
// - Secondary bit 4 makes the serial-peripheral source high priority.
// - Each source gets a level, independent of its enable bit.
// - A high-level request may preempt a running low-level routine.
// - Simultaneous requests of both levels: high level served first.
// - A routine is never preempted by a same-level request.
// - Same-level ties resolve in the fixed polling order.
// - Entry pushes the program counter, then loads the vector.
// - Vectors are eight bytes apart from 0003H to 005BH, skipping 004BH.
// - Interval match in power-down wakes and vectors to 0053H.
module two_level_interrupt_priority (
  input  wire logic        clk_i,             // Core clock, 20 MHz.
  input  wire logic        rst_i,             // Synchronous reset, high.
  input  wire logic        wb_cyc_i,          // Wishbone cycle.
  input  wire logic        wb_stb_i,          // Wishbone strobe.
  input  wire logic        wb_we_i,           // Wishbone write enable.
  input  wire logic [11:0] wb_adr_i,          // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,          // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,          // Wishbone write data.
  output logic      [31:0] wb_dat_o,          // Wishbone read data.
  output logic             wb_ack_o,          // Wishbone acknowledge.
  input  wire logic        supply_monitor_request_i, // Supply monitor.
  input  wire logic        watchdog_request_i,       // Watchdog.
  input  wire logic        external_request_zero_i,  // External 0.
  input  wire logic [1:0]  converter_done_i,         // Converter flags.
  input  wire logic        timer_zero_overflow_i,    // Timer 0.
  input  wire logic        external_request_one_i,   // External 1.
  input  wire logic        timer_one_overflow_i,     // Timer 1.
  input  wire logic [1:0]  serial_periph_request_i,  // Peripheral flags.
  input  wire logic [1:0]  serial_port_request_i,    // Receive, transmit.
  input  wire logic [1:0]  timer_two_events_i,       // Timer 2 flags.
  input  wire logic        interval_match_flag_i,    // Interval match.
  input  wire logic        core_ready_i,      // Core at an entry point.
  input  wire logic        core_return_i,     // Core ran a return.
  input  wire logic        power_down_i,      // Core is powered down.
  output logic             push_pc_o,         // Push program counter.
  output logic             load_pc_o,         // Load vector into PC.
  output logic      [15:0] vector_o,          // Vector address.
  output logic             irq_pending_o,     // A request is waiting.
  output logic             wake_o,            // Wake from power-down.
  output logic             irq_o              // Event interrupt level.
);

  // --------------------------------------------------------------------
  // Register storage and internal state.
  // --------------------------------------------------------------------
  logic [7:0]  secondary_irq_enable_priority_reg;
  logic [7:0]  primary_enable_reg;
  logic [7:0]  primary_prio_reg;
  logic [7:0]  event_status_reg;
  logic [7:0]  event_mask_reg;
  logic        act_hi_reg;
  logic        act_lo_reg;
  logic [3:0]  taken_idx_reg;
  logic        taken_level_reg;
  irq_prio_pkg::entry_state_t state_reg;

  logic [10:0] raw_req;
  logic [10:0] enable_vec;
  logic [10:0] high_vec;
  logic [10:0] pend;
  logic        win_valid;
  logic [3:0]  win_idx;
  logic        win_level;
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic [9:0]  bus_idx;
  logic        hit_sec;
  logic        hit_pen;
  logic        hit_ppr;
  logic        hit_cst;
  logic        hit_est;
  logic        hit_emk;
  logic        wake_cond;
  logic        entry_evt;
  logic        stray_evt;
  logic [7:0]  evt_set;
  logic [7:0]  rd_data;
  logic [7:0]  core_status;

  // --------------------------------------------------------------------
  // Request gathering.
  // --------------------------------------------------------------------
  // combined shared requests.
  always_comb begin
    raw_req = '0;
    raw_req[irq_prio_pkg::SRC_SUPPLY]     = supply_monitor_request_i;
    raw_req[irq_prio_pkg::SRC_WATCHDOG]   = watchdog_request_i;
    raw_req[irq_prio_pkg::SRC_EXT0]       = external_request_zero_i;
    raw_req[irq_prio_pkg::SRC_CONVERTER]  = |converter_done_i;
    raw_req[irq_prio_pkg::SRC_TIMER0]     = timer_zero_overflow_i;
    raw_req[irq_prio_pkg::SRC_EXT1]       = external_request_one_i;
    raw_req[irq_prio_pkg::SRC_TIMER1]     = timer_one_overflow_i;
    raw_req[irq_prio_pkg::SRC_SER_PERIPH] = |serial_periph_request_i;
    raw_req[irq_prio_pkg::SRC_SERIAL]     = |serial_port_request_i;
    raw_req[irq_prio_pkg::SRC_TIMER2]     = |timer_two_events_i;
    raw_req[irq_prio_pkg::SRC_INTERVAL]   = interval_match_flag_i;
  end

  // Per-source enables; the watchdog is gated by its own controller.
  always_comb begin
    enable_vec = '0;
    enable_vec[irq_prio_pkg::SRC_SUPPLY] =
      secondary_irq_enable_priority_reg[irq_prio_pkg::SEC_SUPPLY_MON_EN];
    enable_vec[irq_prio_pkg::SRC_WATCHDOG] = 1'b1;
    enable_vec[irq_prio_pkg::SRC_EXT0] =
      primary_enable_reg[irq_prio_pkg::PRI_EXT0];
    enable_vec[irq_prio_pkg::SRC_CONVERTER] =
      primary_enable_reg[irq_prio_pkg::PRI_CONVERTER];
    enable_vec[irq_prio_pkg::SRC_TIMER0] =
      primary_enable_reg[irq_prio_pkg::PRI_TIMER0];
    enable_vec[irq_prio_pkg::SRC_EXT1] =
      primary_enable_reg[irq_prio_pkg::PRI_EXT1];
    enable_vec[irq_prio_pkg::SRC_TIMER1] =
      primary_enable_reg[irq_prio_pkg::PRI_TIMER1];
    enable_vec[irq_prio_pkg::SRC_SER_PERIPH] =
      secondary_irq_enable_priority_reg[irq_prio_pkg::SEC_SERIAL_PERIPH_EN];
    enable_vec[irq_prio_pkg::SRC_SERIAL] =
      primary_enable_reg[irq_prio_pkg::PRI_SERIAL];
    enable_vec[irq_prio_pkg::SRC_TIMER2] =
      primary_enable_reg[irq_prio_pkg::PRI_TIMER2];
    enable_vec[irq_prio_pkg::SRC_INTERVAL] =
      secondary_irq_enable_priority_reg[irq_prio_pkg::SEC_INTERVAL_EN];
  end

  // Per-source levels, held apart from the enables.
  // independent level select.
  always_comb begin
    high_vec = '0;
    high_vec[irq_prio_pkg::SRC_SUPPLY] =
      secondary_irq_enable_priority_reg[irq_prio_pkg::SEC_SUPPLY_MON_PRIO];
    high_vec[irq_prio_pkg::SRC_WATCHDOG] =
      primary_prio_reg[irq_prio_pkg::PRI_WATCHDOG];
    high_vec[irq_prio_pkg::SRC_EXT0] =
      primary_prio_reg[irq_prio_pkg::PRI_EXT0];
    high_vec[irq_prio_pkg::SRC_CONVERTER] =
      primary_prio_reg[irq_prio_pkg::PRI_CONVERTER];
    high_vec[irq_prio_pkg::SRC_TIMER0] =
      primary_prio_reg[irq_prio_pkg::PRI_TIMER0];
    high_vec[irq_prio_pkg::SRC_EXT1] =
      primary_prio_reg[irq_prio_pkg::PRI_EXT1];
    high_vec[irq_prio_pkg::SRC_TIMER1] =
      primary_prio_reg[irq_prio_pkg::PRI_TIMER1];
    high_vec[irq_prio_pkg::SRC_SER_PERIPH] =
      secondary_irq_enable_priority_reg[irq_prio_pkg::SEC_SERIAL_PERIPH_PRIO];
    high_vec[irq_prio_pkg::SRC_SERIAL] =
      primary_prio_reg[irq_prio_pkg::PRI_SERIAL];
    high_vec[irq_prio_pkg::SRC_TIMER2] =
      primary_prio_reg[irq_prio_pkg::PRI_TIMER2];
    high_vec[irq_prio_pkg::SRC_INTERVAL] =
      secondary_irq_enable_priority_reg[irq_prio_pkg::SEC_INTERVAL_PRIO];
  end

  // In power-down only the interval counter can bring the core back.
  // power-down wake source.
  assign wake_cond = power_down_i &
    raw_req[irq_prio_pkg::SRC_INTERVAL] &
    enable_vec[irq_prio_pkg::SRC_INTERVAL] &
    primary_enable_reg[irq_prio_pkg::PRI_GLOBAL_EN];

  // Gate by enables and the global enable; power-down narrows the set.
  always_comb begin
    pend = raw_req & enable_vec &
           {11{primary_enable_reg[irq_prio_pkg::PRI_GLOBAL_EN]}};
    if (power_down_i) begin
      pend = '0;
      pend[irq_prio_pkg::SRC_INTERVAL] = wake_cond;
    end
  end

  // --------------------------------------------------------------------
  // Arbitration.
  // --------------------------------------------------------------------
  irq_arbiter u_arbiter (
    .pend_i   (pend),
    .high_i   (high_vec),
    .act_hi_i (act_hi_reg),
    .act_lo_i (act_lo_reg),
    .valid_o  (win_valid),
    .idx_o    (win_idx),
    .level_o  (win_level)
  );

  // --------------------------------------------------------------------
  // Entry sequencer: idle, push the PC, then load the vector.
  // --------------------------------------------------------------------
  // push then load.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg       <= irq_prio_pkg::ST_IDLE;
      taken_idx_reg   <= 4'h0;
      taken_level_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        irq_prio_pkg::ST_IDLE: begin
          if (win_valid && (core_ready_i || power_down_i)) begin
            taken_idx_reg   <= win_idx;
            taken_level_reg <= win_level;
            state_reg       <= irq_prio_pkg::ST_PUSH;
          end
        end
        irq_prio_pkg::ST_PUSH: begin
          state_reg <= irq_prio_pkg::ST_LOAD;
        end
        irq_prio_pkg::ST_LOAD: begin
          state_reg <= irq_prio_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= irq_prio_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Core-facing strobes and vector, all registered.
  // vector lookup.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_pc_o     <= 1'b0;
      load_pc_o     <= 1'b0;
      vector_o      <= 16'h0000;
      irq_pending_o <= 1'b0;
    end else begin
      push_pc_o     <= (state_reg == irq_prio_pkg::ST_PUSH);
      load_pc_o     <= (state_reg == irq_prio_pkg::ST_LOAD);
      irq_pending_o <= win_valid;
      if (state_reg == irq_prio_pkg::ST_PUSH) begin
        vector_o <= irq_prio_pkg::VECTOR_TABLE[taken_idx_reg];
      end
    end
  end

  // Wake is raised while the interval match is pending in power-down.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_cond;
    end
  end

  // Active-level record; entry sets, a return clears the highest level.
  // active level record.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_hi_reg <= 1'b0;
      act_lo_reg <= 1'b0;
    end else begin
      if (core_return_i) begin
        if (act_hi_reg) begin
          act_hi_reg <= 1'b0;
        end else begin
          act_lo_reg <= 1'b0;
        end
      end
      if (state_reg == irq_prio_pkg::ST_LOAD) begin
        if (taken_level_reg) begin
          act_hi_reg <= 1'b1;
        end else begin
          act_lo_reg <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Wishbone slave: one wait state, answer in the second cycle.
  // --------------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_rd  = bus_req & ~wb_we_i;
  assign bus_idx = wb_adr_i[11:2];
  assign hit_sec = (bus_idx == {2'b00, irq_prio_pkg::IDX_SECONDARY});
  assign hit_pen = (bus_idx == {2'b00, irq_prio_pkg::IDX_PRIMARY_ENABLE});
  assign hit_ppr = (bus_idx == {2'b00, irq_prio_pkg::IDX_PRIMARY_PRIO});
  assign hit_cst = (bus_idx == {2'b00, irq_prio_pkg::IDX_CORE_STATUS});
  assign hit_est = (bus_idx == {2'b00, irq_prio_pkg::IDX_EVENT_STATUS});
  assign hit_emk = (bus_idx == {2'b00, irq_prio_pkg::IDX_EVENT_MASK});

  // Acknowledge every addressed cycle, mapped or not.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Software-written registers; the top secondary bit is read-only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      secondary_irq_enable_priority_reg <= irq_prio_pkg::RST_SECONDARY;
      primary_enable_reg <= irq_prio_pkg::RST_PRIMARY_ENABLE;
      primary_prio_reg   <= irq_prio_pkg::RST_PRIMARY_PRIO;
      event_mask_reg     <= irq_prio_pkg::RST_EVENT_MASK;
    end else if (bus_wr) begin
      if (hit_sec) begin
        secondary_irq_enable_priority_reg <= {
          secondary_irq_enable_priority_reg[irq_prio_pkg::SEC_UNUSED_TOP],
          wb_dat_i[6:0]};
      end
      if (hit_pen) begin
        primary_enable_reg <= wb_dat_i[7:0];
      end
      if (hit_ppr) begin
        primary_prio_reg <= wb_dat_i[7:0];
      end
      if (hit_emk) begin
        event_mask_reg <= wb_dat_i[7:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Sticky events; a read clears them, a new event wins over the clear.
  // --------------------------------------------------------------------
  assign entry_evt = (state_reg == irq_prio_pkg::ST_LOAD);
  assign stray_evt = core_return_i & ~act_hi_reg & ~act_lo_reg;

  always_comb begin
    evt_set = 8'h00;
    evt_set[irq_prio_pkg::EVT_ENTRY]      = entry_evt;
    evt_set[irq_prio_pkg::EVT_WAKE]       = wake_cond & ~wake_o;
    evt_set[irq_prio_pkg::EVT_STRAY_RETI] = stray_evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_status_reg <= 8'h00;
    end else if (bus_rd && hit_est) begin
      event_status_reg <= evt_set;
    end else begin
      event_status_reg <= event_status_reg | evt_set;
    end
  end

  // Interrupt output, high while an unmasked event bit is set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(event_status_reg & event_mask_reg);
    end
  end

  // --------------------------------------------------------------------
  // Read path.
  // --------------------------------------------------------------------
  assign core_status = {1'b0, power_down_i, taken_idx_reg,
                        act_hi_reg, act_lo_reg};

  always_comb begin
    rd_data = 8'h00;
    if (hit_sec) begin
      rd_data = secondary_irq_enable_priority_reg;
    end else if (hit_pen) begin
      rd_data = primary_enable_reg;
    end else if (hit_ppr) begin
      rd_data = primary_prio_reg;
    end else if (hit_cst) begin
      rd_data = core_status;
    end else if (hit_est) begin
      rd_data = event_status_reg;
    end else if (hit_emk) begin
      rd_data = event_mask_reg;
    end
  end

  // Read data is captured with the acknowledge and zero otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      wb_dat_o <= {24'h00_0000, rd_data};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule
